// ===== hdl/idmm_pkg.sv
// Constants for the internal data memory map: RAM regions, banks, core registers.
// Assumes a single core clock domain and a CPU execution unit as the only client.
package idmm_pkg;
    // ------------------------------------------------------------
    // Sizes and regions
    // ------------------------------------------------------------
    localparam int unsigned RAM_BYTES = 128;
    localparam logic [7:0] RAM_TOP = 8'h7f;
    localparam logic [7:0] BANK_AREA_TOP = 8'h1f;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam logic [7:0] BIT_AREA_TOP = 8'h2f;
    localparam logic [7:0] SCRATCH_BASE = 8'h30;
    localparam logic [7:0] SFR_BASE = 8'h80;
    localparam logic [7:0] BIT_SFR_FIRST = 8'h80;
    // ------------------------------------------------------------
    // Core registers in the special-function space
    // ------------------------------------------------------------
    localparam logic [7:0] STACK_POINTER_ADDR = 8'h81;
    localparam logic [7:0] DATA_POINTER_LOW_ADDR = 8'h82;
    localparam logic [7:0] DATA_POINTER_HIGH_ADDR = 8'h83;
    localparam logic [7:0] PROGRAM_STATUS_WORD_ADDR = 8'hd0;
    localparam logic [7:0] ACCUMULATOR_REGISTER_ADDR = 8'he0;
    localparam logic [7:0] B_REGISTER_ADDR = 8'hf0;
    // ------------------------------------------------------------
    // Reset values and fields
    // ------------------------------------------------------------
    localparam logic [7:0] STACK_POINTER_RESET = 8'h07;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam int unsigned BANK_SELECT_LOW_BIT = 3;
    localparam int unsigned BANK_SELECT_HIGH_BIT = 4;
    localparam logic [1:0] BANK_RESET = 2'h0;
    localparam logic [7:0] SP_STEP = 8'h01;
    // Access kinds issued by the CPU
    typedef enum logic [1:0] {
        IDMM_DIRECT,
        IDMM_INDIRECT,
        IDMM_REGISTER,
        IDMM_BIT
    } idmm_mode_t;
    // Stack operations
    typedef enum logic [1:0] {
        IDMM_STK_NONE,
        IDMM_STK_PUSH,
        IDMM_STK_POP
    } idmm_stack_t;
endpackage

// ===== hdl/idmm_core.sv
// Internal data memory map: 128-byte RAM, register banks, bit area and core SFRs.
// Assumes the CPU presents one access per cycle; read data is registered.
`timescale 1ns/1ps
module idmm_core (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic acc_valid,
    input wire idmm_pkg::idmm_mode_t acc_mode,
    input wire logic acc_write,
    input wire logic [7:0] acc_addr,
    input wire logic [2:0] acc_reg_index,
    input wire logic acc_pointer_sel,
    input wire logic [7:0] acc_wdata,
    input wire logic acc_bit_wdata,
    input wire idmm_pkg::idmm_stack_t stack_op,
    input wire logic [7:0] stack_wdata,
    input wire logic ext_move,
    input wire logic ext_use_pointer_reg,
    output logic [7:0] acc_rdata,
    output logic acc_bit_rdata,
    output logic acc_error,
    output logic [7:0] stack_rdata,
    output logic [15:0] ext_addr,
    output logic ext_valid,
    output logic [7:0] sfr_addr,
    output logic sfr_read,
    output logic sfr_write,
    output logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    output logic [7:0] accumulator_register,
    output logic [7:0] program_status_word,
    output logic [7:0] stack_pointer,
    output logic [1:0] active_bank
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] ram_q [0:idmm_pkg::RAM_BYTES-1];
    logic [7:0] acc_q;
    logic [7:0] psw_q;
    logic [7:0] sp_q;
    logic [7:0] b_q;
    logic [7:0] dpl_q;
    logic [7:0] dph_q;
    logic [7:0] rdata_q;
    logic bit_rdata_q;
    logic error_q;
    logic [7:0] stack_rdata_q;
    logic [15:0] ext_addr_q;
    logic ext_valid_q;

    // Bit address to byte address; used for RAM and SFR bit maps
    function automatic logic [7:0] bit_byte(input logic [7:0] b);
        if (!b[7]) begin
            bit_byte = idmm_pkg::BIT_AREA_BASE + {4'h0, b[6:3]};
        end else begin
            bit_byte = {b[7:3], 3'h0};
        end
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire [1:0] bank = {psw_q[idmm_pkg::BANK_SELECT_HIGH_BIT],
                       psw_q[idmm_pkg::BANK_SELECT_LOW_BIT]};
    wire [7:0] reg_addr = {3'h0, bank, acc_reg_index};
    wire [7:0] ptr_addr = {3'h0, bank, 2'h0, acc_pointer_sel};
    wire [7:0] ptr_value = ram_q[ptr_addr[6:0]];
    wire is_direct = acc_mode == idmm_pkg::IDMM_DIRECT;
    wire is_indirect = acc_mode == idmm_pkg::IDMM_INDIRECT;
    wire is_register = acc_mode == idmm_pkg::IDMM_REGISTER;
    wire is_bit = acc_mode == idmm_pkg::IDMM_BIT;
    wire [7:0] eff_addr = is_register ? reg_addr :
                          is_indirect ? ptr_value :
                          is_bit ? bit_byte(acc_addr) : acc_addr;
    wire [2:0] bit_pos = acc_addr[2:0];
    wire in_sfr = eff_addr >= idmm_pkg::SFR_BASE;
    // Indirect at 80h and up has no RAM behind it in a 128-byte part
    wire indirect_out = is_indirect && in_sfr;
    wire ram_hit = acc_valid && !in_sfr && !indirect_out;
    wire sfr_hit = acc_valid && in_sfr && (is_direct || is_bit);
    wire hit_acc = eff_addr == idmm_pkg::ACCUMULATOR_REGISTER_ADDR;
    wire hit_psw = eff_addr == idmm_pkg::PROGRAM_STATUS_WORD_ADDR;
    wire hit_sp = eff_addr == idmm_pkg::STACK_POINTER_ADDR;
    wire hit_b = eff_addr == idmm_pkg::B_REGISTER_ADDR;
    wire hit_dpl = eff_addr == idmm_pkg::DATA_POINTER_LOW_ADDR;
    wire hit_dph = eff_addr == idmm_pkg::DATA_POINTER_HIGH_ADDR;
    wire hit_core = hit_acc || hit_psw || hit_sp || hit_b || hit_dpl || hit_dph;
    wire [7:0] core_rd = hit_acc ? acc_q :
                         hit_psw ? psw_q :
                         hit_sp ? sp_q :
                         hit_b ? b_q :
                         hit_dpl ? dpl_q : dph_q;
    // Others go out to peripheral SFR owners
    wire [7:0] sfr_byte = hit_core ? core_rd : sfr_rdata;
    wire [7:0] old_byte = in_sfr ? sfr_byte : ram_q[eff_addr[6:0]];
    // Bit writes are read-modify-write of the same byte, so views agree
    wire [7:0] bit_merged = (old_byte & ~(8'h01 << bit_pos)) |
                            ({7'h0, acc_bit_wdata} << bit_pos);
    wire [7:0] wr_byte = is_bit ? bit_merged : acc_wdata;
    wire do_write = acc_valid && acc_write && !indirect_out;

    // ------------------------------------------------------------
    // Stack
    // ------------------------------------------------------------
    wire push = stack_op == idmm_pkg::IDMM_STK_PUSH;
    wire pop = stack_op == idmm_pkg::IDMM_STK_POP;
    wire [7:0] sp_inc = sp_q + idmm_pkg::SP_STEP;
    wire [7:0] sp_dec = sp_q - idmm_pkg::SP_STEP;
    // Stack wraps inside RAM; pointer bit 7 ignored for storage
    wire [6:0] push_slot = sp_inc[6:0];
    wire [7:0] sp_d = push ? sp_inc : pop ? sp_dec :
                      (do_write && hit_sp && in_sfr) ? wr_byte : sp_q;

    // ------------------------------------------------------------
    // External data address
    // ------------------------------------------------------------
    wire [15:0] ext_addr_d = ext_use_pointer_reg ? {8'h00, ptr_value} :
                             {dph_q, dpl_q};

    // ------------------------------------------------------------
    // Write enables and next values
    // ------------------------------------------------------------
    wire sfr_wr = do_write && in_sfr;
    wire ram_wr = ram_hit && do_write;
    wire acc_wr = sfr_wr && hit_acc;
    wire psw_wr = sfr_wr && hit_psw;
    wire b_wr = sfr_wr && hit_b;
    wire dpl_wr = sfr_wr && hit_dpl;
    wire dph_wr = sfr_wr && hit_dph;
    // Refused indirect reads give zero, never a stale RAM byte
    wire [7:0] rdata_d = indirect_out ? idmm_pkg::ZERO_BYTE : old_byte;
    wire bit_rdata_d = old_byte[bit_pos];
    wire error_d = acc_valid && indirect_out;
    // Pop takes the byte the pointer names before stepping down
    wire [7:0] stack_rdata_d = ram_q[sp_q[6:0]];

    // ------------------------------------------------------------
    // RAM array
    // ------------------------------------------------------------
    // No reset on the array; contents after power-up are undefined
    always_ff @(posedge clock) begin
        if (ram_wr) begin
            ram_q[eff_addr[6:0]] <= wr_byte;
        end
        // Second, so a push wins over a write to the same slot
        if (push) begin
            ram_q[push_slot] <= stack_wdata;
        end
    end

    // ------------------------------------------------------------
    // Core special-function registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            acc_q <= idmm_pkg::ZERO_BYTE;
        end else if (acc_wr) begin
            acc_q <= wr_byte;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            psw_q <= idmm_pkg::ZERO_BYTE;
        end else if (psw_wr) begin
            psw_q <= wr_byte;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sp_q <= idmm_pkg::STACK_POINTER_RESET;
        end else begin
            sp_q <= sp_d;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            b_q <= idmm_pkg::ZERO_BYTE;
        end else if (b_wr) begin
            b_q <= wr_byte;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dpl_q <= idmm_pkg::ZERO_BYTE;
        end else if (dpl_wr) begin
            dpl_q <= wr_byte;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dph_q <= idmm_pkg::ZERO_BYTE;
        end else if (dph_wr) begin
            dph_q <= wr_byte;
        end
    end

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------
    // Read data holds until the next access, so a slow consumer still sees it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= idmm_pkg::ZERO_BYTE;
        end else if (acc_valid) begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bit_rdata_q <= 1'b0;
        end else if (acc_valid) begin
            bit_rdata_q <= bit_rdata_d;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            error_q <= 1'b0;
        end else begin
            error_q <= error_d;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stack_rdata_q <= idmm_pkg::ZERO_BYTE;
        end else if (pop) begin
            stack_rdata_q <= stack_rdata_d;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ext_valid_q <= 1'b0;
        end else begin
            ext_valid_q <= ext_move;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ext_addr_q <= 16'h0000;
        end else if (ext_move) begin
            ext_addr_q <= ext_addr_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign acc_rdata = rdata_q;
    assign acc_bit_rdata = bit_rdata_q;
    assign acc_error = error_q;
    assign stack_rdata = stack_rdata_q;
    assign ext_addr = ext_addr_q;
    assign ext_valid = ext_valid_q;
    assign sfr_addr = eff_addr;
    assign sfr_read = sfr_hit && !hit_core;
    assign sfr_write = sfr_hit && acc_write && !hit_core;
    assign sfr_wdata = wr_byte;
    assign accumulator_register = acc_q;
    assign program_status_word = psw_q;
    assign stack_pointer = sp_q;
    assign active_bank = bank;
endmodule // idmm_core

// ===== test/idmm_sfr_model.sv
// Owner of the special-function registers outside the core set.
// Assumes the core strobes one address at a time and reads combinationally.
`timescale 1ns/1ps
module idmm_sfr_model (
    input wire logic clock,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_read,
    input wire logic sfr_write,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata
);
    // ----------------------------------------
    // Storage and reply
    // ----------------------------------------
    logic [7:0] mem [256];
    logic [7:0] junk_q = 8'h00;
    always @(posedge clock) begin
        junk_q <= junk_q + 8'h5b;
        if (sfr_write) mem[sfr_addr] <= sfr_wdata;
    end
    // Moving pattern when idle, so a stale byte never passes
    assign sfr_rdata = sfr_read ? mem[sfr_addr] : junk_q;
endmodule // idmm_sfr_model

// ===== test/idmm_core_chk.sv
// Checker for the data memory map core, bound to its ports.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module idmm_core_chk (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic acc_valid,
    input wire idmm_pkg::idmm_mode_t acc_mode,
    input wire logic acc_write,
    input wire logic [7:0] acc_addr,
    input wire logic [7:0] acc_wdata,
    input wire idmm_pkg::idmm_stack_t stack_op,
    input wire logic ext_move,
    input wire logic ext_valid,
    input wire logic acc_error,
    input wire logic sfr_read,
    input wire logic sfr_write,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] accumulator_register,
    input wire logic [7:0] program_status_word,
    input wire logic [7:0] stack_pointer,
    input wire logic [1:0] active_bank
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    wire push = stack_op == idmm_pkg::IDMM_STK_PUSH;
    wire pop = stack_op == idmm_pkg::IDMM_STK_POP;
    wire bitm = acc_mode == idmm_pkg::IDMM_BIT;
    wire dirm = acc_mode == idmm_pkg::IDMM_DIRECT;
    wire strobe = sfr_read || sfr_write;
    property p_sp_rst; $rose(reset_n) |-> stack_pointer == 8'h07; endproperty
    a_sp_rst: assert property (p_sp_rst) else $error("stack pointer not 07h");
    property p_bank; active_bank == program_status_word[4:3]; endproperty
    a_bank: assert property (p_bank) else $error("bank differs from status");
    property p_push; push |=> stack_pointer == $past(stack_pointer) + 8'h01; endproperty
    a_push: assert property (p_push) else $error("push did not step up");
    property p_pop; pop && !push |=> stack_pointer == $past(stack_pointer) - 8'h01; endproperty
    a_pop: assert property (p_pop) else $error("pop did not step down");
    property p_err; acc_error |-> $past(acc_valid && acc_mode == idmm_pkg::IDMM_INDIRECT); endproperty
    a_err: assert property (p_err) else $error("error without indirect access");
    property p_sfr_dir; strobe |-> acc_valid && (dirm || bitm) && acc_addr[7]; endproperty
    a_sfr_dir: assert property (p_sfr_dir) else $error("strobe not from direct");
    property p_sfr_bit; sfr_read && bitm |-> sfr_addr == {acc_addr[7:3], 3'h0}; endproperty
    a_sfr_bit: assert property (p_sfr_bit) else $error("bit owner byte wrong");
    property p_acc; acc_valid && acc_write && dirm && acc_addr == 8'he0 && !push
        |=> accumulator_register == $past(acc_wdata); endproperty
    a_acc: assert property (p_acc) else $error("accumulator not written");
    property p_ext; ext_valid == $past(ext_move); endproperty
    a_ext: assert property (p_ext) else $error("external strobe out of step");
    c_push: cover property (push);
    c_err: cover property (acc_error);
    c_bit: cover property (sfr_read && bitm);
endmodule // idmm_core_chk
bind idmm_core idmm_core_chk u_chk (.clock, .reset_n, .acc_valid, .acc_mode, .acc_write,
    .acc_addr, .acc_wdata, .stack_op, .ext_move, .ext_valid, .acc_error, .sfr_read, .sfr_write,
    .sfr_addr, .accumulator_register, .program_status_word, .stack_pointer, .active_bank);

// ===== test/idmm_core_tb.sv
// Bench for the data memory map core: RAM, banks, bits, SFRs, stack, external moves.
// Assumes the SFR owner model on the strobe side and the bound checker.
`timescale 1ns/1ps
module idmm_core_tb;
    // ----------------------------------------
    // Signals, reference model and tasks
    // ----------------------------------------
    localparam idmm_pkg::idmm_mode_t DIR = idmm_pkg::IDMM_DIRECT;
    localparam idmm_pkg::idmm_mode_t BIT = idmm_pkg::IDMM_BIT;
    logic clock, reset_n, acc_valid, acc_write, acc_pointer_sel, acc_bit_wdata, ext_move;
    logic ext_use_pointer_reg, acc_bit_rdata, acc_error, ext_valid, sfr_read, sfr_write;
    logic [7:0] acc_addr, acc_wdata, stack_wdata, sfr_rdata, acc_rdata, stack_rdata, sfr_addr;
    logic [7:0] sfr_wdata, accumulator_register, program_status_word, stack_pointer;
    logic [2:0] acc_reg_index;
    logic [1:0] active_bank;
    logic [15:0] ext_addr;
    idmm_pkg::idmm_mode_t acc_mode;
    idmm_pkg::idmm_stack_t stack_op;
    int err_count = 32'h0, n_tests = 32'h0, seed = 32'h7580, ram [128], b, n, p, v;
    idmm_core dut (.clock, .reset_n, .acc_valid, .acc_mode, .acc_write, .acc_addr, .acc_reg_index,
        .acc_pointer_sel, .acc_wdata, .acc_bit_wdata, .stack_op, .stack_wdata, .ext_move,
        .ext_use_pointer_reg, .acc_rdata, .acc_bit_rdata, .acc_error, .stack_rdata, .ext_addr,
        .ext_valid, .sfr_addr, .sfr_read, .sfr_write, .sfr_wdata, .sfr_rdata,
        .accumulator_register, .program_status_word, .stack_pointer, .active_bank);
    idmm_sfr_model peer (.clock, .sfr_addr, .sfr_read, .sfr_write, .sfr_wdata, .sfr_rdata);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: read %h, model %h", $time, got, exp);
        end
    endtask
    task automatic go(input idmm_pkg::idmm_mode_t m, input logic w, input logic [7:0] a,
        input logic [7:0] d);
        acc_mode = m;
        acc_write = w;
        acc_addr = a;
        acc_reg_index = a[2:0];
        acc_pointer_sel = a[0];
        acc_wdata = d;
        acc_bit_wdata = d[0];
        acc_valid = 1'h1;
        @(posedge clock);
        // Valid stays up; only the stack and external tasks lower it
        #1;
    endtask
    task automatic stk(input idmm_pkg::idmm_stack_t o, input logic [7:0] d);
        acc_valid = 1'h0;
        stack_op = o;
        stack_wdata = d;
        @(posedge clock);
        #1 stack_op = idmm_pkg::IDMM_STK_NONE;
    endtask
    task automatic ext(input logic u);
        acc_valid = 1'h0;
        ext_use_pointer_reg = u;
        ext_move = 1'h1;
        @(posedge clock);
        #1 ext_move = 1'h0;
    endtask
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end
    // Whole run is under a thousand cycles
    initial begin
        #50000;
        err_count++;
        give_verdict();
    end
    initial begin
        {reset_n, acc_valid, acc_write, acc_pointer_sel, acc_bit_wdata, ext_move} = '0;
        {ext_use_pointer_reg, acc_addr, acc_wdata, stack_wdata, acc_reg_index} = '0;
        acc_mode = DIR;
        stack_op = idmm_pkg::IDMM_STK_NONE;
        repeat (8) @(posedge clock);
        #1 reset_n = 1'h1;
        chk(stack_pointer, 8'h07);
        chk(8'(active_bank), 8'h00);
        for (n = 0; n < 128; n++) begin
            v = $random(seed) & 32'hff;
            ram[n] = v;
            go(DIR, 1'h1, n[7:0], v[7:0]);
        end
        for (n = 0; n < 128; n++) begin
            go(DIR, 1'h0, n[7:0], 8'h00);
            chk(acc_rdata, ram[n][7:0]);
        end
        for (b = 0; b < 4; b++) begin
            go(DIR, 1'h1, 8'hd0, {3'h0, b[1:0], 3'h0});
            chk(8'(active_bank), 8'(b[1:0]));
            chk(program_status_word, {3'h0, b[1:0], 3'h0});
            n = $random(seed) & 32'h7;
            v = $random(seed) & 32'hff;
            p = 8 * b + n;
            ram[p] = v;
            go(idmm_pkg::IDMM_REGISTER, 1'h1, n[7:0], v[7:0]);
            go(DIR, 1'h0, p[7:0], 8'h00);
            chk(acc_rdata, v[7:0]);
        end
        for (n = 0; n < 4; n++) begin
            p = 24 + n % 2;
            v = (n < 2) ? ($random(seed) & 32'h3f) | 32'h40 : 32'h90 + (n - 2) * 32'h50;
            ram[p] = v;
            go(DIR, 1'h1, p[7:0], v[7:0]);
            go(idmm_pkg::IDMM_INDIRECT, 1'h1, n[7:0], 8'h5a);
            chk(8'(acc_error), 8'(n > 1));
            if (v < 128) ram[v] = 32'h5a;
            go(idmm_pkg::IDMM_INDIRECT, 1'h0, n[7:0], 8'h00);
            chk(acc_rdata, (v < 128) ? 8'h5a : 8'h00);
        end
        chk(accumulator_register, 8'h00);
        for (n = 0; n < 16; n++) begin
            v = $random(seed);
            b = v & 32'h7f;
            p = 32 + b / 8;
            ram[p][b % 8] = v[8];
            go(BIT, 1'h1, b[7:0], {7'h0, v[8]});
            go(DIR, 1'h0, p[7:0], 8'h00);
            chk(acc_rdata, ram[p][7:0]);
            go(BIT, 1'h0, b[7:0], 8'h00);
            chk(8'(acc_bit_rdata), 8'(v[8]));
        end
        $display("ram, bank and bit tests done");
        go(DIR, 1'h1, 8'h90, 8'h0f);
        go(BIT, 1'h1, 8'h93, 8'h00);
        go(DIR, 1'h0, 8'h90, 8'h00);
        chk(acc_rdata, 8'h07);
        v = $random(seed);
        go(DIR, 1'h1, 8'he0, v[7:0]);
        chk(accumulator_register, v[7:0]);
        go(BIT, 1'h0, 8'he7, 8'h00);
        chk(8'(acc_bit_rdata), 8'(v[7]));
        stk(idmm_pkg::IDMM_STK_PUSH, v[15:8]);
        chk(stack_pointer, 8'h08);
        go(DIR, 1'h0, 8'h08, 8'h00);
        chk(acc_rdata, v[15:8]);
        stk(idmm_pkg::IDMM_STK_POP, 8'h00);
        chk(stack_rdata, v[15:8]);
        chk(stack_pointer, 8'h07);
        go(DIR, 1'h1, 8'h81, 8'h7e);
        stk(idmm_pkg::IDMM_STK_PUSH, 8'h3c);
        go(DIR, 1'h0, 8'h7f, 8'h00);
        chk(acc_rdata, 8'h3c);
        go(DIR, 1'h1, 8'h82, 8'h34);
        go(DIR, 1'h1, 8'h83, 8'h12);
        ext(1'h0);
        chk(8'(ext_valid), 8'h01);
        chk(ext_addr[15:8], 8'h12);
        chk(ext_addr[7:0], 8'h34);
        go(DIR, 1'h0, 8'h19, 8'h00);
        chk(acc_rdata, ram[25][7:0]);
        ext(1'h1);
        chk(ext_addr[15:8], 8'h00);
        chk(ext_addr[7:0], ram[25][7:0]);
        $display("sfr, stack and external tests done");
        // Reset again with bank three and a moved stack; both must return
        reset_n = 1'h0;
        @(posedge clock);
        #1 reset_n = 1'h1;
        chk(stack_pointer, 8'h07);
        chk(8'(active_bank), 8'h00);
        $display("mid-run reset test done");
        give_verdict();
    end
endmodule // idmm_core_tb
